//--- logic/gpc_gpio.sv
/*
 * Six-port general-purpose pin block with APB register access, lock
 * logic, alternate function and additional function pad muxing.
 * Assumes an APB master on REF_CLK and pad cells that resolve the
 * output, active-low output enable and pull controls into the wire.
 */
// Added by the designer: the address map and register access over APB.
module gpc_gpio
	import gpc_pkg::*;
(
	// clock and reset
	input  logic                      REF_CLK,
	input  logic                      RST,
	// apb slave
	input  logic                      PSEL,
	input  logic                      PENABLE,
	input  logic                      PWRITE,
	input  logic [15:0]               PADDR,
	input  logic [31:0]               PWDATA,
	output logic [31:0]               PRDATA,
	output logic                      PREADY,
	output logic                      PSLVERR,
	// pads
	input  logic [gpc_pkg::NPIN-1:0]  PIN_IN,
	output logic [gpc_pkg::NPIN-1:0]  PIN_OUT,
	output logic [gpc_pkg::NPIN-1:0]  PIN_OE_N,
	output logic [gpc_pkg::NPIN-1:0]  PIN_PU,
	output logic [gpc_pkg::NPIN-1:0]  PIN_PD,
	output logic [gpc_pkg::NPIN-1:0]  PIN_IE,
	output logic [2*gpc_pkg::NPIN-1:0] PIN_SPEED,
	// alternate functions, sixteen per pin
	input  logic [16*gpc_pkg::NPIN-1:0] AF_DO,
	input  logic [16*gpc_pkg::NPIN-1:0] AF_OE,
	output logic [gpc_pkg::NPIN-1:0]  AF_DI,
	// additional functions from clock, power and analog owners
	input  logic [gpc_pkg::NPIN-1:0]  ADDF_EN,
	input  logic [gpc_pkg::NPIN-1:0]  ADDF_DO,
	input  logic [gpc_pkg::NPIN-1:0]  ADDF_OE,
	input  logic [gpc_pkg::NPIN-1:0]  ADDF_ANA
);

	import gpc_pkg::*;

	typedef enum logic [3:0] {
		LK_IDLE = 4'h1,
		LK_ONE  = 4'h2,
		LK_ZERO = 4'h4,
		LK_SET  = 4'h8
	} gpc_lk_t;

	typedef struct packed {
		logic [NPORT-1:0][31:0] mode;
		logic [NPORT-1:0][31:0] speed;
		logic [NPORT-1:0][31:0] pull;
		logic [NPORT-1:0][31:0] afl;
		logic [NPORT-1:0][31:0] afh;
		logic [NPORT-1:0][15:0] drv;
		logic [NPORT-1:0][15:0] octl;
		logic [NPORT-1:0][15:0] istat;
		logic [NPORT-1:0][15:0] lkbits;
		logic [NPORT-1:0]       lock_key_bit;
		gpc_lk_t [NPORT-1:0]    lk;
		logic [31:0]            rdata;
	} gpc_state_t;

	gpc_state_t      state_ff;
	gpc_state_t      nxt_state;
	logic [NPIN-1:0] pin_sync;
	logic [NPIN-1:0] ie_pin;
	logic            acc;
	logic            wr;
	logic            port_ok;
	logic            hit;
	logic [9:0]      ofs;

	function automatic logic [31:0] dup2(input logic [15:0] m);
		logic [31:0] r;
		r = '0;
		for (int i = 0; i < 16; i++) begin
			r[2*i +: 2] = {2{m[i]}};
		end
		return r;
	endfunction

	function automatic logic [31:0] dup4(input logic [7:0] m);
		logic [31:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			r[4*i +: 4] = {4{m[i]}};
		end
		return r;
	endfunction

	function automatic logic [15:0] pmask(input int p);
		return (p == NPORT - 1) ? LAST_MASK : FULL_MASK;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [31:0] m);
		return (o & ~m) | (n & m);
	endfunction

	function automatic logic known_ofs(input logic [9:0] o);
		case (o)
			OFS_MODE, OFS_DRV, OFS_SPEED, OFS_PULL, OFS_ISTAT, OFS_OCTL,
			OFS_BOP, OFS_LOCK, OFS_AFL, OFS_AFH, OFS_BC, OFS_TG: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	gpc_sync u_sync (
		.ref_clk  (REF_CLK),
		.rst      (RST),
		.pin_in   (PIN_IN),
		.pin_sync (pin_sync)
	);

	assign acc     = PSEL & PENABLE;
	assign wr      = acc & PWRITE;
	assign ofs     = PADDR[9:0];
	assign port_ok = (PADDR[15:PORT_LSB] < 6'(NPORT));
	assign hit     = port_ok & known_ofs(ofs);
	// zero wait states; read data is captured during the setup cycle
	assign PREADY  = 1'b1;
	assign PSLVERR = acc & ~hit;
	assign PRDATA  = state_ff.rdata;

	always_comb begin
		int          p;
		logic [15:0] m;
		logic [15:0] fz;
		logic [15:0] wb;
		logic [15:0] kb;
		logic        key;
		p   = 0;
		m   = '0;
		fz  = '0;
		wb  = '0;
		kb  = '0;
		key = 1'b0;
		nxt_state = state_ff;

		for (int i = 0; i < NPIN; i++) begin
			nxt_state.istat[i / PW][i % PW] = pin_sync[i] & ie_pin[i];
		end

		if (port_ok) begin
			p = int'(PADDR[15:PORT_LSB]);
		end
		m  = pmask(p);
		fz = state_ff.lock_key_bit[p] ? state_ff.lkbits[p] : 16'h0000;
		wb = PWDATA[15:0] & m;

		if (PSEL && !PENABLE) begin
			nxt_state.rdata = REG_RST;
			if (hit && !PWRITE) begin
				case (ofs)
					OFS_MODE:  nxt_state.rdata = state_ff.mode[p];
					OFS_DRV:   nxt_state.rdata = {16'h0000, state_ff.drv[p]};
					OFS_SPEED: nxt_state.rdata = state_ff.speed[p];
					OFS_PULL:  nxt_state.rdata = state_ff.pull[p];
					OFS_ISTAT: nxt_state.rdata = {16'h0000, state_ff.istat[p]};
					OFS_OCTL:  nxt_state.rdata = {16'h0000, state_ff.octl[p]};
					OFS_LOCK:  nxt_state.rdata = {15'h0000, state_ff.lock_key_bit[p], state_ff.lkbits[p]};
					OFS_AFL:   nxt_state.rdata = state_ff.afl[p];
					OFS_AFH:   nxt_state.rdata = state_ff.afh[p];
					default:   nxt_state.rdata = REG_RST;
				endcase
			end
		end

		if (wr && hit) begin
			case (ofs)
				OFS_MODE: begin
					nxt_state.mode[p] = merge(state_ff.mode[p], PWDATA, dup2(m & ~fz));
				end
				OFS_DRV: begin
					nxt_state.drv[p] = 16'(merge({16'h0000, state_ff.drv[p]}, PWDATA, {16'h0000, m & ~fz}));
				end
				OFS_SPEED: begin
					nxt_state.speed[p] = merge(state_ff.speed[p], PWDATA, dup2(m & ~fz));
				end
				OFS_PULL: begin
					nxt_state.pull[p] = merge(state_ff.pull[p], PWDATA, dup2(m & ~fz));
				end
				OFS_AFL: begin
					nxt_state.afl[p] = merge(state_ff.afl[p], PWDATA, dup4(m[7:0] & ~fz[7:0]));
				end
				OFS_AFH: begin
					nxt_state.afh[p] = merge(state_ff.afh[p], PWDATA, dup4(m[15:8] & ~fz[15:8]));
				end
				OFS_OCTL: begin
					nxt_state.octl[p] = wb;
				end
				// one write is the whole change, other bits untouched
				OFS_BOP: begin
					nxt_state.octl[p] = state_ff.octl[p] | wb;
				end
				OFS_BC: begin
					nxt_state.octl[p] = state_ff.octl[p] & ~wb;
				end
				OFS_TG: begin
					nxt_state.octl[p] = state_ff.octl[p] ^ wb;
				end
				OFS_LOCK: begin
					kb  = wb;
					key = PWDATA[LKK_POS];
					// key sequence 1, 0, 1 with identical pin bits; any slip restarts it
					case (state_ff.lk[p])
						LK_IDLE: begin
							nxt_state.lkbits[p] = kb;
							if (key) begin
								nxt_state.lk[p] = LK_ONE;
							end
						end
						LK_ONE: begin
							nxt_state.lkbits[p] = kb;
							if (!key && kb == state_ff.lkbits[p]) begin
								nxt_state.lk[p] = LK_ZERO;
							end else if (!key) begin
								nxt_state.lk[p] = LK_IDLE;
							end
						end
						LK_ZERO: begin
							nxt_state.lkbits[p] = kb;
							if (key && kb == state_ff.lkbits[p]) begin
								nxt_state.lk[p]  = LK_SET;
								nxt_state.lock_key_bit[p] = 1'b1;
							end else begin
								nxt_state.lk[p] = key ? LK_ONE : LK_IDLE;
							end
						end
						LK_SET: begin
							nxt_state.lk[p] = LK_SET;
						end
						default: begin
							nxt_state.lk[p] = LK_IDLE;
						end
					endcase
				end
				default: begin
				end
			endcase
		end

		// only reset clears the lock
		if (RST) begin
			nxt_state = '0;
			for (int k = 0; k < NPORT; k++) begin
				nxt_state.lk[k] = LK_IDLE;
			end
			nxt_state.mode[DBG_PORT] = MODE_RST_DBG;
			nxt_state.pull[DBG_PORT] = PULL_RST_DBG;
		end
	end

	always_ff @(posedge REF_CLK) begin
		state_ff <= nxt_state;
	end

	// pad mux; additional function wins over the port mode and pulls, pad speed still comes from the port setup
	always_comb begin
		int         p;
		int         b;
		logic [1:0] md;
		logic [1:0] pl;
		logic [3:0] sel;
		logic       dat;
		logic       en;
		logic       od;
		p   = 0;
		b   = 0;
		md  = MD_IN;
		pl  = 2'h0;
		sel = 4'h0;
		dat = 1'b0;
		en  = 1'b0;
		od  = 1'b0;
		PIN_OUT   = '0;
		PIN_OE_N  = '1;
		PIN_PU    = '0;
		PIN_PD    = '0;
		ie_pin    = '0;
		AF_DI     = '0;
		PIN_SPEED = '0;
		for (int i = 0; i < NPIN; i++) begin
			p   = i / PW;
			b   = i % PW;
			md  = state_ff.mode[p][2*b +: 2];
			pl  = state_ff.pull[p][2*b +: 2];
			sel = (b < 8) ? state_ff.afl[p][4*b +: 4] : state_ff.afh[p][4*(b-8) +: 4];
			dat = 1'b0;
			en  = 1'b0;
			od  = 1'b0;
			ie_pin[i] = 1'b1;
			PIN_PU[i] = (pl == PL_UP);
			PIN_PD[i] = (pl == PL_DN);
			PIN_SPEED[2*i +: 2] = state_ff.speed[p][2*b +: 2];
			if (ADDF_EN[i]) begin
				// the owning unit sets the pin type itself
				dat = ADDF_DO[i];
				en  = ADDF_OE[i];
				ie_pin[i] = ~ADDF_ANA[i];
				PIN_PU[i] = 1'b0;
				PIN_PD[i] = 1'b0;
			end else begin
				case (md)
					MD_OUT: begin
						dat = state_ff.octl[p][b];
						en  = 1'b1;
						od  = state_ff.drv[p][b];
					end
					MD_AF: begin
						dat = AF_DO[i*NAF + int'(sel)];
						en  = AF_OE[i*NAF + int'(sel)];
						od  = state_ff.drv[p][b];
						AF_DI[i] = pin_sync[i];
					end
					MD_ANA: begin
						ie_pin[i] = 1'b0;
						PIN_PU[i] = 1'b0;
						PIN_PD[i] = 1'b0;
					end
					default: begin
					end
				endcase
			end
			// open-drain releases the pad for a one
			PIN_OE_N[i] = ~(en & ~(od & dat));
			PIN_OUT[i]  = dat & ~od;
			PIN_IE[i]   = ie_pin[i];
		end
	end

	// assertions watch pins 0 and 1 of port 0, port 1 debug setup, and pins 33, 48, 49 for analog and function muxing
	logic wr0;
	assign wr0 = wr && PADDR[15:10] == 6'h00;

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RST);

	input_float_a : assert property (
		state_ff.mode[0][1:0] == MD_IN && !ADDF_EN[0] |-> PIN_OE_N[0] && PIN_IE[0])
		else $error("input mode pin is driven");

	set_bit_a : assert property (
		wr0 && PADDR[9:0] == OFS_BOP && PWDATA[0] |=> state_ff.octl[0][0])
		else $error("set write did not set the bit");

	clear_bit_a : assert property (
		wr0 && PADDR[9:0] == OFS_BC && PWDATA[0] |=> !state_ff.octl[0][0])
		else $error("clear write did not clear the bit");

	keep_zero_a : assert property (
		wr0 && (PADDR[9:0] == OFS_TG || PADDR[9:0] == OFS_BOP) && !PWDATA[1]
		|=> state_ff.octl[0][1] == $past(state_ff.octl[0][1]))
		else $error("bit written zero changed");

	toggle_pin_a : assert property (
		wr0 && PADDR[9:0] == OFS_TG && PWDATA[0] && state_ff.mode[0][1:0] == MD_OUT
		&& !state_ff.drv[0][0] && !ADDF_EN[0] ##1 state_ff.mode[0][1:0] == MD_OUT && !ADDF_EN[0]
		|-> PIN_OUT[0] != $past(PIN_OUT[0]))
		else $error("toggle did not flip the pin in one cycle");

	od_release_a : assert property (
		state_ff.mode[0][1:0] == MD_OUT && state_ff.drv[0][0] && !ADDF_EN[0]
		|-> PIN_OE_N[0] == state_ff.octl[0][0] && !PIN_OUT[0])
		else $error("open-drain pad level wrong");

	af_dir_a : assert property (
		state_ff.mode[3][1:0] == MD_AF && !state_ff.drv[3][0] && !ADDF_EN[48]
		|-> PIN_OE_N[48] == !AF_OE[48*NAF + int'(state_ff.afl[3][3:0])])
		else $error("alternate pad direction wrong");

	analog_zero_a : assert property (
		(state_ff.mode[2][3:2] == MD_ANA && !ADDF_EN[33])[*2] |-> !state_ff.istat[2][1] && !PIN_PU[33])
		else $error("analog pin reads nonzero or pulled");

	sample_pin_a : assert property (
		(state_ff.mode[0][1:0] == MD_IN && !ADDF_EN[0])[*4] |-> state_ff.istat[0][0] == $past(PIN_IN[0], 3))
		else $error("input status lags pin");

	lock_hold_a : assert property (
		state_ff.lock_key_bit[0] && state_ff.lkbits[0][0] |=> state_ff.mode[0][1:0] == $past(state_ff.mode[0][1:0])
		&& state_ff.lock_key_bit[0])
		else $error("locked pin setup changed");

	debug_reset_a : assert property (
		$past(RST) |-> state_ff.pull[DBG_PORT] == PULL_RST_DBG && state_ff.mode[DBG_PORT] == MODE_RST_DBG)
		else $error("debug port reset setup wrong");

	addf_over_a : assert property (
		ADDF_EN[49] |-> PIN_OE_N[49] == !ADDF_OE[49] && PIN_OUT[49] == ADDF_DO[49])
		else $error("additional function not in control");

endmodule // gpc_gpio

//--- logic/gpc_pkg.sv
/*
 * Shared constants for the general-purpose port block: sizes,
 * register offsets inside one port window, field codes and reset values.
 * Assumes a 20 MHz bus clock and an APB master with 16-bit byte addresses.
 */
package gpc_pkg;

	localparam int          NPORT     = 6;
	localparam int          NPIN      = 88;
	localparam int          PW        = 16;
	localparam int          NAF       = 16;
	localparam int          PORT_LSB  = 10;
	localparam int          LKK_POS   = 16;
	localparam logic [15:0] FULL_MASK = 16'hFFFF;
	localparam logic [15:0] LAST_MASK = 16'h00FF;

	// byte offsets inside one port window
	localparam logic [9:0] OFS_MODE  = 10'h000;
	localparam logic [9:0] OFS_DRV   = 10'h004;
	localparam logic [9:0] OFS_SPEED = 10'h008;
	localparam logic [9:0] OFS_PULL  = 10'h00C;
	localparam logic [9:0] OFS_ISTAT = 10'h010;
	localparam logic [9:0] OFS_OCTL  = 10'h014;
	localparam logic [9:0] OFS_BOP   = 10'h018;
	localparam logic [9:0] OFS_LOCK  = 10'h01C;
	localparam logic [9:0] OFS_AFL   = 10'h020;
	localparam logic [9:0] OFS_AFH   = 10'h024;
	localparam logic [9:0] OFS_BC    = 10'h028;
	localparam logic [9:0] OFS_TG    = 10'h02C;

	// pin mode field codes
	localparam logic [1:0] MD_IN  = 2'h0;
	localparam logic [1:0] MD_OUT = 2'h1;
	localparam logic [1:0] MD_AF  = 2'h2;
	localparam logic [1:0] MD_ANA = 2'h3;

	// pull select field codes
	localparam logic [1:0] PL_UP = 2'h1;
	localparam logic [1:0] PL_DN = 2'h2;

	// reset values; the debug port differs from the others
	localparam int          DBG_PORT     = 1;
	localparam logic [31:0] REG_RST      = 32'h0000_0000;
	localparam logic [31:0] MODE_RST_DBG = 32'h000A_8280;
	localparam logic [31:0] PULL_RST_DBG = 32'h0006_4040;

endpackage : gpc_pkg

//--- logic/gpc_sync.sv
/*
 * Two-stage synchroniser for all package pin levels.
 * Assumes pin inputs are asynchronous to the bus clock.
 */
module gpc_sync
	import gpc_pkg::*;
(
	// clock and reset
	input  logic            ref_clk,
	input  logic            rst,
	// pin levels
	input  logic [NPIN-1:0] pin_in,
	output logic [NPIN-1:0] pin_sync
);

	typedef struct packed {
		logic [NPIN-1:0] s1;
		logic [NPIN-1:0] s2;
	} gpc_sync_t;

	gpc_sync_t state_ff;
	gpc_sync_t nxt_state;

	// first stage feeds only the second stage
	always_comb begin
		nxt_state.s1 = pin_in;
		nxt_state.s2 = state_ff.s1;
		if (rst) begin
			nxt_state = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		state_ff <= nxt_state;
	end

	assign pin_sync = state_ff.s2;

endmodule // gpc_sync

//--- verification/gpc_pad_model.sv
/*
 * Pad and board model for the general-purpose port block: resolves each
 * pin wire from the block's drive, enable and pull controls, plus an
 * external driver that the bench can switch on per pin.
 * Assumes one clock, REF_CLK, and pad controls that settle before each edge.
 */
module gpc_pad_model
	import gpc_pkg::*;
(
	// clock
	input  logic            ref_clk,
	// block side of the pads
	input  logic [NPIN-1:0] pin_out,
	input  logic [NPIN-1:0] pin_oe_n,
	input  logic [NPIN-1:0] pin_pu,
	input  logic [NPIN-1:0] pin_pd,
	// board driver
	input  logic [NPIN-1:0] ext_en,
	input  logic [NPIN-1:0] ext_val,
	// resolved wire
	output logic [NPIN-1:0] pin_lvl
);
	// known start value: a floating wire must toggle, not read as unknown
	logic            flt_ff = 1'b0;
	logic            nxt_flt;
	logic [NPIN-1:0] drv;

	// a floating wire flips each cycle so a missing pull never reads as a stable level
	assign nxt_flt = ~flt_ff;
	always_ff @(posedge ref_clk) begin
		flt_ff <= nxt_flt;
	end

	// released open-drain output falls to the pulls or floats
	assign drv = ~pin_oe_n;
	assign pin_lvl = (ext_en & ext_val) | (~ext_en & drv & pin_out)
		| (~ext_en & ~drv & (pin_pu | (~pin_pd & {NPIN{flt_ff}})));
endmodule // gpc_pad_model

//--- verification/gpio_port_control_tb_top.sv
/*
 * Self-checking bench for the port block: APB register traffic, pad
 * outputs, input sampling, alternate and additional function muxing, lock.
 * Assumes a zero-wait APB slave and the pad model beside the block.
 */
module gpio_port_control_tb_top;
	import gpc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [NPIN-1:0] pin_in, pin_out, pin_oe_n, pin_pu, pin_pd, pin_ie, af_di;
	logic [NPIN-1:0] addf_en, addf_do, addf_oe, addf_ana, ext_en, ext_val;
	logic [2*NPIN-1:0] pin_speed;
	logic [16*NPIN-1:0] af_do, af_oe;
	int fails, samples_checked;
	logic [9:0] ofs [3] = '{OFS_BOP, OFS_BC, OFS_TG};
	logic [31:0] odat [3] = '{32'h0000_000F, 32'h0000_0030, 32'h0000_00FF};
	logic [31:0] oexp [3] = '{32'h0000_123F, 32'h0000_120F, 32'h0000_12F0};

	gpc_gpio u_dut (.REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n), .PIN_PU(pin_pu), .PIN_PD(pin_pd),
		.PIN_IE(pin_ie), .PIN_SPEED(pin_speed), .AF_DO(af_do), .AF_OE(af_oe), .AF_DI(af_di),
		.ADDF_EN(addf_en), .ADDF_DO(addf_do), .ADDF_OE(addf_oe), .ADDF_ANA(addf_ana));

	gpc_pad_model u_pads (.ref_clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pu(pin_pu),
		.pin_pd(pin_pd), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_in));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	function automatic logic [15:0] ad(input logic [5:0] p, input logic [9:0] o);
		return {p, o};
	endfunction

	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	// one transfer; starts after an edge so back-to-back calls never collide
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) fails++;
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [15:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask

	task automatic done(input string n);
		$display("test %s done", n);
	endtask

	task automatic stop_test;
		$display("checked %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		stop_test();
	end

	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 51'h0};
		{af_do, af_oe, addf_en, addf_do, addf_oe, addf_ana, ext_en, ext_val} = '0;
		fails = 0;
		samples_checked = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(ad(1, OFS_MODE)); check("mode1", MODE_RST_DBG, rdat);
		rd(ad(1, OFS_PULL)); check("pull1", PULL_RST_DBG, rdat);
		rd(ad(0, OFS_MODE)); check("mode0", REG_RST, rdat);
		check("oe", 32'hFFFF_FFFF, pin_oe_n[31:0]);
		check("pu1", 32'h0000_0288, 32'(pin_pu[31:16]));
		check("pd1", 32'h0000_0100, 32'(pin_pd[31:16]));
		check("pupd0", 32'h0, {pin_pu[15:0], pin_pd[15:0]});
		done("reset");
		wr(ad(0, OFS_MODE), 32'h5555_5555);
		wr(ad(0, OFS_SPEED), 32'h0000_000B);
		wr(ad(0, OFS_OCTL), 32'h0000_1234);
		#1 check("out0", 32'h0000_1234, 32'(pin_out[15:0]));
		check("oe0", 32'h0, 32'(pin_oe_n[15:0]));
		check("spd0", 32'h0000_000B, 32'(pin_speed[3:0]));
		// each write is checked 1 ns after the edge that commits it
		for (int i = 0; i < 3; i++) begin
			wr(ad(0, ofs[i]), odat[i]);
			#1 check("setclr", oexp[i], 32'(pin_out[15:0]));
		end
		rd(ad(0, OFS_OCTL)); check("octl", 32'h0000_12F0, rdat);
		wr(ad(0, OFS_DRV), 32'h0000_FFFF);
		#1 check("od_oe", 32'h0000_12F0, 32'(pin_oe_n[15:0]));
		check("od_out", 32'h0, 32'(pin_out[15:0]));
		wr(ad(0, OFS_DRV), 32'h0);
		done("output");
		wr(ad(0, OFS_LOCK), 32'h0001_0001);
		wr(ad(0, OFS_LOCK), 32'h0000_0001);
		wr(ad(0, OFS_LOCK), 32'h0001_0001);
		rd(ad(0, OFS_LOCK)); check("lock", 32'h0001_0001, rdat);
		wr(ad(0, OFS_MODE), 32'h0);
		rd(ad(0, OFS_MODE)); check("lk_mode", 32'h0000_0001, rdat);
		wr(ad(0, OFS_SPEED), 32'h0);
		rd(ad(0, OFS_SPEED)); check("lk_spd", 32'h0000_0003, rdat);
		done("lock");
		wr(ad(2, OFS_PULL), 32'h0000_00E4);
		#1 check("pu2", 32'h2, 32'(pin_pu[35:32]));
		check("pd2", 32'h4, 32'(pin_pd[35:32]));
		@(posedge clk);
		ext_en[47:32] <= 16'hFFFF;
		ext_val[47:32] <= 16'hA5C3;
		repeat (4) @(posedge clk);
		rd(ad(2, OFS_ISTAT)); check("istat", 32'h0000_A5C3, rdat);
		wr(ad(2, OFS_MODE), 32'h0000_000C);
		repeat (4) @(posedge clk);
		rd(ad(2, OFS_ISTAT)); check("ana_st", 32'h0000_A5C1, rdat);
		check("ana_ie", 32'h1, 32'(pin_ie[33:32]));
		check("ana_pu", 32'h0, 32'(pin_pu[33]));
		// pin 33 carries an analog function, pin 32 an owner-set oscillator pin
		@(posedge clk);
		addf_en[33:32] <= 2'b11;
		addf_ana[33:32] <= 2'b11;
		#1 check("addf_ana", 32'h3, 32'({pin_ie[33:32], pin_oe_n[33:32]}));
		@(posedge clk);
		{addf_en[33:32], addf_ana[33:32]} <= 4'h0;
		done("input");
		wr(ad(3, OFS_MODE), 32'h0000_000A);
		wr(ad(3, OFS_AFL), 32'h0000_0005);
		@(posedge clk);
		af_do[48*16+5] <= 1'b1;
		af_oe[48*16+5] <= 1'b1;
		#1 check("af_oe", 32'h0, 32'(pin_oe_n[48]));
		check("af_out", 32'h1, 32'(pin_out[48]));
		repeat (4) @(posedge clk);
		check("af_di", 32'h1, 32'(af_di[48]));
		af_oe[48*16+5] <= 1'b0;
		addf_en[49] <= 1'b1;
		addf_oe[49] <= 1'b1;
		addf_do[49] <= 1'b1;
		#1 check("af_in", 32'h1, 32'(pin_oe_n[48]));
		check("addf", 32'h2, 32'({pin_out[49], pin_oe_n[49]}));
		@(posedge clk);
		addf_en[49] <= 1'b0;
		#1 check("addf_off", 32'h1, 32'(pin_oe_n[49]));
		done("functions");
		wr(ad(5, OFS_OCTL), 32'h0000_FFFF);
		rd(ad(5, OFS_OCTL)); check("port5", 32'h0000_00FF, rdat);
		rd(ad(6, OFS_MODE)); check("err6", 32'h1, 32'(rerr));
		check("rd6", 32'h0, rdat);
		rd(ad(0, 10'h030)); check("err_ofs", 32'h1, 32'(rerr));
		done("map");
		stop_test();
	end
endmodule // gpio_port_control_tb_top
